/* design/fla_pkg.sv */
// Purpose: constants and types for the fuse configuration and lock block
// Assumes: one clock at 20 MHz
// Notes: fuse bytes and the key live in an outside store
`default_nettype none
package fla_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_MS_NS = 1000000; // one millisecond
  localparam int CYC_PER_MS = T_MS_NS / CLK_PERIOD_NS;
  // register offsets
  localparam logic [3:0] OFF_SYS_CONFIG_0 = 4'h5;
  localparam logic [3:0] OFF_SYS_CONFIG_1 = 4'h6;
  localparam logic [3:0] OFF_CODE_REGION = 4'h7;
  localparam logic [3:0] OFF_BOOT_REGION = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'h9;
  localparam logic [3:0] OFF_CONTROL = 4'ha;
  // field positions
  localparam int RSTPIN_BIT = 3;
  localparam int KEEP_BIT = 0;
  localparam int SUPPLY_LSB = 3;
  localparam int DELAY_CODE_LSB = 0;
  localparam int CLR_DENIED_BIT = 0;
  // values
  localparam logic [31:0] KEY_VALID = 32'h5cc5c55c;
  localparam logic [1:0] SUPPLY_DUAL = 2'h1;
  localparam logic [1:0] SUPPLY_SINGLE = 2'h2;
  localparam logic [7:0] READ_INVALID = 8'h00;
  localparam logic [16:0] FLASH_BYTES = 17'h08000; // flash size in bytes
  // memory sections seen by the debug port
  typedef enum logic [2:0] {
    SP_FLASH = 3'h0, SP_SRAM = 3'h1, SP_EEPROM = 3'h2, SP_SIGNATURE = 3'h3,
    SP_USER_CFG = 3'h4, SP_FUSE = 3'h5, SP_LOCK = 3'h6, SP_REGS = 3'h7
  } fla_space_t;
  // sequencer states
  typedef enum logic [4:0] {
    ST_INIT = 5'h01, ST_WAIT = 5'h02, ST_RUN = 5'h04, ST_ERASE = 5'h08, ST_KEYSET = 5'h10
  } fla_state_t;
  // 512-byte blocks to bytes
  function automatic logic [16:0] blocks_to_bytes(input logic [7:0] b);
    return {b, 9'h000};
  endfunction
  // start-up delay code to milliseconds
  function automatic logic [6:0] ms_for_code(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'(7'h01 << (c - 3'h1));
  endfunction
endpackage
`default_nettype wire

/* design/fla_acc_if.sv */
// Purpose: carries one debug access to the permission check
// Assumes: combinational answer
// Notes: none
`default_nettype none
interface fla_acc_if;
  import fla_pkg::*;
  fla_space_t space;
  logic write;
  logic locked;
  logic allow;
  modport req(output space, output write, output locked, input allow);
  modport chk(input space, input write, input locked, output allow);
endinterface
`default_nettype wire

/* design/fla_access_check.sv */
// Purpose: decides whether a debug access may proceed
// Assumes: lock state supplied by the caller
// Notes: purely combinational
`default_nettype none
module fla_access_check
  import fla_pkg::*;
(
  // access under test
  fla_acc_if.chk acc
);
  // writes: locked lets only the user row through, unlocked bars the signature row
  assign acc.allow = acc.write ? (acc.locked ? (acc.space == SP_USER_CFG)
                                             : (acc.space != SP_SIGNATURE))
                               : !acc.locked;
endmodule // fla_access_check
`default_nettype wire

/* design/fla_startup_timer.sv */
// Purpose: counts the start-up delay in milliseconds
// Assumes: start is a one-cycle pulse
// Notes: done holds until the next start
`default_nettype none
module fla_startup_timer
  import fla_pkg::*;
#(
  parameter int CyclesPerMs = CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic [2:0] delayCode,
  output logic done
);
  logic [20:0] divCnt_reg;
  logic [6:0] msCnt_reg;
  logic [6:0] target_reg;
  logic run_reg;
  wire msTick = divCnt_reg == 21'(CyclesPerMs - 1);

  // millisecond divider and delay counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= 21'h0;
      msCnt_reg <= 7'h00;
      target_reg <= 7'h00;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      divCnt_reg <= 21'h0;
      msCnt_reg <= 7'h00;
      target_reg <= ms_for_code(delayCode);
      run_reg <= 1'b1;
      done <= 1'b0;
    end else if (run_reg) begin
      if (msCnt_reg == target_reg) begin
        run_reg <= 1'b0;
        done <= 1'b1;
      end else if (msTick) begin
        divCnt_reg <= 21'h0;
        msCnt_reg <= msCnt_reg + 7'h01;
      end else begin
        divCnt_reg <= divCnt_reg + 21'h1;
      end
    end
  end

  property p_zero_delay;
    @(posedge clk) disable iff (sys_rst) start && delayCode == 3'h0 |-> ##2 done;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not done in two cycles");
endmodule // fla_startup_timer
`default_nettype wire

/* design/fla_fuse_lock.sv */
// Purpose: fuse start-up configuration and debug access protection
// Assumes: fuse bytes and key come from an outside store on this clock
// Notes: debug answers two cycles after the request
//
// Behaviour
// - select 0 makes the pin a general input, 1 an external reset input.
// - keep bit 0 erases EEPROM on full erase, 1 keeps it.
// - with keep set, full erase clears flash and SRAM only.
// - supply code 1 is dual, 2 single, 0 and 3 reserved.
// - wait 0 to 64 ms after power-on per delay code.
// - code region size is in 512-byte blocks.
// - boot size in 512-byte blocks; zero makes all flash boot.
// - locked device blocks debug reads of flash, SRAM, EEPROM, fuses.
// - CPU permissions do not depend on the lock.
// - any key other than the valid one locks the device.
// - unlocked debug may access all but signature row writes; CPU cannot write protected.
// - locked debug is refused everywhere except user row writes.
// - locked user row accepts writes but never reads back.
// - refused reads complete with invalid data.
// - only full erase unlocks; user row kept, application data gone.
// - unlocked only when key equals the valid value.
`default_nettype none
module fla_fuse_lock
  import fla_pkg::*;
#(
  parameter int CyclesPerMs = CYC_PER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // cpu register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // fuse and key store
  input wire logic [7:0] nvSysCfg0,
  input wire logic [7:0] nvSysCfg1,
  input wire logic [7:0] nvCodeBlocks,
  input wire logic [7:0] nvBootBlocks,
  input wire logic [31:0] nvKey,
  output logic nvWe,
  output logic nvWrKey,
  output logic [3:0] nvWrAddr,
  output logic [7:0] nvWrData,
  output logic keyRestore,
  // debug port
  input wire logic dbgReq,
  input wire logic dbgWrite,
  input wire fla_space_t dbgSpace,
  input wire logic [15:0] dbgAddr,
  input wire logic [7:0] dbgWrData,
  input wire logic dbgErase,
  output logic dbgAck,
  output logic dbgDenied,
  output logic [7:0] dbgRdData,
  // memory port
  output logic memEn,
  output logic memWe,
  output fla_space_t memSpace,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // erase control
  output logic eraseFlash,
  output logic eraseEeprom,
  output logic eraseSram,
  input wire logic eraseDone,
  // reset pin
  input wire logic portFPin6,
  output logic extResetReq,
  output logic pinGpioIn,
  // working configuration
  output logic cpuRun,
  output logic supplyDual,
  output logic supplySingle,
  output logic [16:0] bootEndAddr,
  output logic [16:0] codeEndAddr
);
  fla_state_t state_reg, state_next;
  logic [7:0] cfg0_reg, cfg1_reg, codeBlk_reg, bootBlk_reg;
  logic pinMeta_reg, pinSync_reg;
  logic cpuDenied_reg;
  logic s1Valid_reg, s1Allow_reg, s1Internal_reg;
  logic [7:0] s1Data_reg;
  logic timerDone;
  fla_acc_if acc ();

  // lock state follows the stored key at all times
  wire locked = nvKey != KEY_VALID;
  wire eraseBusy = (state_reg == ST_ERASE) || (state_reg == ST_KEYSET);
  wire eraseGo = dbgErase && ((state_reg == ST_WAIT) || (state_reg == ST_RUN));
  wire keepOnErase = cfg0_reg[KEEP_BIT];
  wire rstPinSel = cfg0_reg[RSTPIN_BIT];
  wire [1:0] supplyCode = cfg1_reg[SUPPLY_LSB +: 2];
  wire supplyReserved = (supplyCode != SUPPLY_DUAL) && (supplyCode != SUPPLY_SINGLE);

  // permission check for the incoming debug request
  assign acc.space = dbgSpace;
  assign acc.write = dbgWrite;
  assign acc.locked = locked;
  fla_access_check u_check (
    .acc(acc)
  );
  wire dbgOk = acc.allow && !eraseBusy;
  wire toMem = (dbgSpace != SP_FUSE) && (dbgSpace != SP_LOCK);

  // internal read data for fuse and key sections
  wire [7:0] fuseRd = (dbgAddr[3:0] == OFF_SYS_CONFIG_0) ? nvSysCfg0 :
                      (dbgAddr[3:0] == OFF_SYS_CONFIG_1) ? nvSysCfg1 :
                      (dbgAddr[3:0] == OFF_CODE_REGION) ? nvCodeBlocks :
                      (dbgAddr[3:0] == OFF_BOOT_REGION) ? nvBootBlocks : 8'h00;
  wire [7:0] keyRd = nvKey[{dbgAddr[1:0], 3'b000} +: 8];
  wire [7:0] intRd = (dbgSpace == SP_LOCK) ? keyRd : fuseRd;

  // cpu register read decode
  wire [7:0] statusWord = {3'b000, supplyReserved, cpuDenied_reg, eraseBusy, cpuRun, locked};
  wire [7:0] regRdMux = (regAddr == OFF_SYS_CONFIG_0) ? cfg0_reg :
                        (regAddr == OFF_SYS_CONFIG_1) ? cfg1_reg :
                        (regAddr == OFF_CODE_REGION) ? codeBlk_reg :
                        (regAddr == OFF_BOOT_REGION) ? bootBlk_reg :
                        (regAddr == OFF_STATUS) ? statusWord : 8'h00;
  // cpu writes to fuse copies are refused whatever the lock says
  wire cpuFuseWr = regWr && (regAddr >= OFF_SYS_CONFIG_0) && (regAddr <= OFF_BOOT_REGION);
  wire clrDenied = regWr && (regAddr == OFF_CONTROL) && regWrData[CLR_DENIED_BIT];

  // start-up delay timer, started as the fuse copies are taken
  fla_startup_timer #(
    .CyclesPerMs(CyclesPerMs)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(state_reg == ST_INIT),
    .delayCode(nvSysCfg1[DELAY_CODE_LSB +: 3]),
    .done(timerDone)
  );

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: state_next = ST_WAIT;
      ST_WAIT: begin
        if (eraseGo) state_next = ST_ERASE;
        else if (timerDone) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (eraseGo) state_next = ST_ERASE;
      end
      ST_ERASE: begin
        if (eraseDone) state_next = ST_KEYSET;
      end
      ST_KEYSET: state_next = ST_INIT;
      default: state_next = ST_INIT;
    endcase
  end

  // sequencer, erase strobes and key restore
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_INIT;
      cpuRun <= 1'b0;
      eraseFlash <= 1'b0;
      eraseEeprom <= 1'b0;
      eraseSram <= 1'b0;
      keyRestore <= 1'b0;
    end else begin
      state_reg <= state_next;
      cpuRun <= state_next == ST_RUN;
      eraseFlash <= eraseGo;
      eraseSram <= eraseGo;
      eraseEeprom <= eraseGo && !keepOnErase;
      keyRestore <= (state_reg == ST_ERASE) && eraseDone;
    end
  end

  // working copies of the fuse fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg0_reg <= 8'h00;
      cfg1_reg <= 8'h00;
      codeBlk_reg <= 8'h00;
      bootBlk_reg <= 8'h00;
    end else if (state_reg == ST_INIT) begin
      cfg0_reg <= nvSysCfg0;
      cfg1_reg <= nvSysCfg1;
      codeBlk_reg <= nvCodeBlocks;
      bootBlk_reg <= nvBootBlocks;
    end
  end

  // decoded configuration outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      supplyDual <= 1'b0;
      supplySingle <= 1'b0;
      bootEndAddr <= 17'h0;
      codeEndAddr <= 17'h0;
    end else begin
      supplyDual <= supplyCode == SUPPLY_DUAL;
      supplySingle <= supplyCode == SUPPLY_SINGLE;
      bootEndAddr <= (bootBlk_reg == 8'h00) ? FLASH_BYTES : blocks_to_bytes(bootBlk_reg);
      codeEndAddr <= blocks_to_bytes(codeBlk_reg);
    end
  end

  // reset pin: synchronise, then route to reset or general input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_reg <= 1'b1;
      pinSync_reg <= 1'b1;
      extResetReq <= 1'b0;
      pinGpioIn <= 1'b0;
    end else begin
      pinMeta_reg <= portFPin6;
      pinSync_reg <= pinMeta_reg;
      extResetReq <= rstPinSel && !pinSync_reg;
      pinGpioIn <= !rstPinSel && pinSync_reg;
    end
  end

  // cpu register port; refused fuse writes raise a sticky flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
      cpuDenied_reg <= 1'b0;
    end else begin
      regRdData <= regRd ? regRdMux : 8'h00;
      if (cpuFuseWr) cpuDenied_reg <= 1'b1;
      else if (clrDenied) cpuDenied_reg <= 1'b0;
    end
  end

  // debug first stage: drive memory or the fuse store
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memEn <= 1'b0;
      memWe <= 1'b0;
      memSpace <= SP_FLASH;
      memAddr <= 16'h0;
      memWrData <= 8'h00;
      nvWe <= 1'b0;
      nvWrKey <= 1'b0;
      nvWrAddr <= 4'h0;
      nvWrData <= 8'h00;
      s1Valid_reg <= 1'b0;
      s1Allow_reg <= 1'b0;
      s1Internal_reg <= 1'b0;
      s1Data_reg <= 8'h00;
    end else begin
      memEn <= dbgReq && dbgOk && toMem;
      memWe <= dbgReq && dbgOk && toMem && dbgWrite;
      memSpace <= dbgSpace;
      memAddr <= dbgAddr;
      memWrData <= dbgWrData;
      nvWe <= dbgReq && dbgOk && !toMem && dbgWrite;
      nvWrKey <= dbgSpace == SP_LOCK;
      nvWrAddr <= dbgAddr[3:0];
      nvWrData <= dbgWrData;
      s1Valid_reg <= dbgReq;
      s1Allow_reg <= dbgOk;
      s1Internal_reg <= !toMem;
      s1Data_reg <= intRd;
    end
  end

  // debug second stage: answer, invalid data when refused
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbgAck <= 1'b0;
      dbgDenied <= 1'b0;
      dbgRdData <= 8'h00;
    end else begin
      dbgAck <= s1Valid_reg;
      dbgDenied <= s1Valid_reg && !s1Allow_reg;
      dbgRdData <= !s1Allow_reg ? READ_INVALID : s1Internal_reg ? s1Data_reg : memRdData;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_lockedRead;
    dbgReq && !dbgWrite && locked;
  endsequence
  sequence s_refusedAnswer;
    dbgAck && dbgDenied && dbgRdData == READ_INVALID;
  endsequence
  property p_locked_read;
    s_lockedRead |-> ##1 !memEn ##1 s_refusedAnswer;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read not refused");

  property p_user_write;
    dbgReq && dbgWrite && dbgSpace == SP_USER_CFG && !eraseBusy |-> ##1 memEn && memWe ##1 dbgAck && !dbgDenied;
  endproperty
  a_user_write: assert property (p_user_write) else $error("user row write refused");

  property p_sig_write;
    dbgReq && dbgWrite && dbgSpace == SP_SIGNATURE |-> ##1 !memEn && !nvWe ##1 dbgDenied;
  endproperty
  a_sig_write: assert property (p_sig_write) else $error("signature row write accepted");

  property p_erase_keep;
    eraseGo |-> ##1 eraseFlash && eraseSram && (eraseEeprom == !keepOnErase);
  endproperty
  a_erase_keep: assert property (p_erase_keep) else $error("erase strobes wrong");

  sequence s_eraseFinish;
    state_reg == ST_ERASE && eraseDone;
  endsequence
  property p_unlock;
    s_eraseFinish |-> ##1 keyRestore && state_reg == ST_KEYSET ##1 state_reg == ST_INIT;
  endproperty
  a_unlock: assert property (p_unlock) else $error("erase did not restore key");

  property p_cpu_write;
    regWr && regAddr == OFF_SYS_CONFIG_1 |-> ##1 cpuDenied_reg && cfg1_reg == $past(cfg1_reg);
  endproperty
  a_cpu_write: assert property (p_cpu_write) else $error("cpu changed a fuse copy");

  property p_pin;
    rstPinSel && !pinSync_reg |-> ##1 extResetReq && !pinGpioIn;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin not honoured");

  property p_copy;
    state_reg == ST_INIT |-> ##1 cfg1_reg == $past(nvSysCfg1) && !cpuRun;
  endproperty
  a_copy: assert property (p_copy) else $error("fuse copy missed");

  property p_boot_all;
    bootBlk_reg == 8'h00 && $stable(bootBlk_reg) |-> ##1 bootEndAddr == FLASH_BYTES;
  endproperty
  a_boot_all: assert property (p_boot_all) else $error("zero boot size not whole flash");
endmodule // fla_fuse_lock
`default_nettype wire

/* verification/fla_store_model.sv */
// Purpose: fuse and key store, memories and erase engine beside the lock block
// Assumes: ld loads the store; erase ends lag cycles after the flash strobe
// Notes: read data outside an access shows the inverse of the last value
`default_nettype none
module fla_store_model
  import fla_pkg::*;
(
  // clock and load
  input wire logic clk,
  input wire logic ld,
  input wire logic [7:0] ldCfg0,
  input wire logic [7:0] ldCfg1,
  input wire logic [7:0] ldCode,
  input wire logic [7:0] ldBoot,
  input wire logic [31:0] ldKey,
  input wire logic [7:0] lag,
  // store side
  input wire logic nvWe,
  input wire logic nvWrKey,
  input wire logic [3:0] nvWrAddr,
  input wire logic [7:0] nvWrData,
  input wire logic keyRestore,
  output logic [7:0] nvSysCfg0,
  output logic [7:0] nvSysCfg1,
  output logic [7:0] nvCodeBlocks,
  output logic [7:0] nvBootBlocks,
  output logic [31:0] nvKey,
  // memory and erase side
  input wire logic memEn,
  input wire logic memWe,
  input wire fla_space_t memSpace,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData,
  input wire logic eraseFlash,
  input wire logic eraseEeprom,
  input wire logic eraseSram,
  output logic eraseDone,
  output logic sawFl,
  output logic sawEe,
  output logic sawSr,
  output logic [11:0] lastWr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg [4];
  logic [31:0] key;
  logic [7:0] lastRd = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic doneR = 1'b0;
  // a load shows through at once so the block never sees unknown fuses
  assign nvSysCfg0 = ld ? ldCfg0 : cfg[0];
  assign nvSysCfg1 = ld ? ldCfg1 : cfg[1];
  assign nvCodeBlocks = ld ? ldCode : cfg[2];
  assign nvBootBlocks = ld ? ldBoot : cfg[3];
  assign nvKey = ld ? ldKey : key;
  assign memRdData = memEn ? (memAddr[7:0] ^ 8'h5a) : ~lastRd;
  assign eraseDone = doneR;
  // store writes, key restore and erase timing
  always @(posedge clk) begin
    if (ld) begin
      cfg[0] <= ldCfg0;
      cfg[1] <= ldCfg1;
      cfg[2] <= ldCode;
      cfg[3] <= ldBoot;
      key <= ldKey;
      sawFl <= 1'b0;
      sawEe <= 1'b0;
      sawSr <= 1'b0;
      lastWr <= 12'h000;
    end else begin
      if (nvWe && nvWrKey) key[{nvWrAddr[1:0], 3'b000} +: 8] <= nvWrData;
      if (nvWe && !nvWrKey && nvWrAddr >= 4'h5 && nvWrAddr <= 4'h8) cfg[2'(nvWrAddr - 4'h5)] <= nvWrData;
      if (keyRestore) key <= KEY_VALID;
      if (eraseFlash) sawFl <= 1'b1;
      if (eraseEeprom) sawEe <= 1'b1;
      if (eraseSram) sawSr <= 1'b1;
      // last memory write taken: valid flag, section, data
      if (memEn && memWe) lastWr <= {1'b1, memSpace, memWrData};
    end
    if (memEn) lastRd <= memAddr[7:0] ^ 8'h5a;
    doneR <= (cnt == 8'h01);
    if (eraseFlash) cnt <= lag;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
endmodule // fla_store_model
`default_nettype wire

/* verification/fla_fuse_lock_bench.sv */
// Purpose: self-checking bench for the fuse configuration and lock block
// Assumes: four cycles stand for one millisecond
// Notes: expectations queue up and a monitor compares them with the answers
`default_nettype none
module fla_fuse_lock_bench
  import fla_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sysRst, regWr, regRd, nvWe, nvWrKey, keyRestore, dbgReq, dbgWrite, dbgErase, dbgAck, dbgDenied;
  logic memEn, memWe, eraseFlash, eraseEeprom, eraseSram, eraseDone, portFPin6, extResetReq, pinGpioIn;
  logic cpuRun, supplyDual, supplySingle, ld, sawFl, sawEe, sawSr, rdPend;
  logic [3:0] regAddr, nvWrAddr;
  logic [7:0] regWrData, regRdData, nvWrData, dbgWrData, dbgRdData, memWrData, memRdData, lagV;
  logic [7:0] nvSysCfg0, nvSysCfg1, nvCodeBlocks, nvBootBlocks, ldCfg0, ldCfg1, ldCode, ldBoot;
  logic [31:0] nvKey, ldKey;
  logic [15:0] dbgAddr, memAddr;
  logic [16:0] bootEndAddr, codeEndAddr;
  logic [11:0] lastWr;
  fla_space_t dbgSpace, memSpace;
  logic [9:0] dbgQ[$];
  logic [15:0] regQ[$];
  int nFail, nTests;
  // clock
  always #25 clk = ~clk;
  fla_fuse_lock #(.CyclesPerMs(4)) dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .nvSysCfg0(nvSysCfg0), .nvSysCfg1(nvSysCfg1),
    .nvCodeBlocks(nvCodeBlocks), .nvBootBlocks(nvBootBlocks), .nvKey(nvKey), .nvWe(nvWe), .nvWrKey(nvWrKey),
    .nvWrAddr(nvWrAddr), .nvWrData(nvWrData), .keyRestore(keyRestore), .dbgReq(dbgReq), .dbgWrite(dbgWrite),
    .dbgSpace(dbgSpace), .dbgAddr(dbgAddr), .dbgWrData(dbgWrData), .dbgErase(dbgErase), .dbgAck(dbgAck),
    .dbgDenied(dbgDenied), .dbgRdData(dbgRdData), .memEn(memEn), .memWe(memWe), .memSpace(memSpace),
    .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData), .eraseFlash(eraseFlash),
    .eraseEeprom(eraseEeprom), .eraseSram(eraseSram), .eraseDone(eraseDone), .portFPin6(portFPin6),
    .extResetReq(extResetReq), .pinGpioIn(pinGpioIn), .cpuRun(cpuRun), .supplyDual(supplyDual),
    .supplySingle(supplySingle), .bootEndAddr(bootEndAddr), .codeEndAddr(codeEndAddr));
  fla_store_model mate (.clk(clk), .ld(ld), .ldCfg0(ldCfg0), .ldCfg1(ldCfg1), .ldCode(ldCode), .ldBoot(ldBoot),
    .ldKey(ldKey), .lag(lagV), .nvWe(nvWe), .nvWrKey(nvWrKey), .nvWrAddr(nvWrAddr), .nvWrData(nvWrData),
    .keyRestore(keyRestore), .nvSysCfg0(nvSysCfg0), .nvSysCfg1(nvSysCfg1), .nvCodeBlocks(nvCodeBlocks),
    .nvBootBlocks(nvBootBlocks), .nvKey(nvKey), .memEn(memEn), .memAddr(memAddr), .memRdData(memRdData),
    .eraseFlash(eraseFlash), .eraseEeprom(eraseEeprom), .eraseDone(eraseDone), .sawFl(sawFl), .sawEe(sawEe),
    .memWe(memWe), .memSpace(memSpace), .memWrData(memWrData), .eraseSram(eraseSram), .sawSr(sawSr),
    .lastWr(lastWr));
  // compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict
  task automatic wrapUp();
    if (nFail == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    regQ.push_back({m, e});
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // debug access; expectation is read flag, refusal, data
  task automatic dbg(input fla_space_t s, input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [9:0] e);
    dbgQ.push_back(e);
    @(posedge clk);
    dbgSpace <= s;
    dbgWrite <= w;
    dbgAddr <= a;
    dbgWrData <= d;
    dbgReq <= 1'b1;
    @(posedge clk);
    dbgReq <= 1'b0;
  endtask
  // load the store, reset, count cycles until the cpu may run
  task automatic boot(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] cs, input logic [7:0] bs,
                      input logic [31:0] k, output int n);
    ld <= 1'b1;
    ldCfg0 <= c0;
    ldCfg1 <= c1;
    ldCode <= cs;
    ldBoot <= bs;
    ldKey <= k;
    sysRst <= 1'b1;
    repeat (12) @(posedge clk);
    ld <= 1'b0;
    sysRst <= 1'b0;
    n = 0;
    while (cpuRun !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // full erase, then wait for the restart
  task automatic erase(input logic [7:0] lg, input logic expEe);
    int n;
    lagV <= lg;
    @(posedge clk);
    dbgErase <= 1'b1;
    @(posedge clk);
    dbgErase <= 1'b0;
    repeat (2) @(posedge clk);
    n = 0;
    while (cpuRun !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({14'h0, sawFl, sawSr, sawEe}, {14'h0, 2'b11, expEe});
    rd(OFF_STATUS, 8'h01, 8'h00);
  endtask
  // monitor: oldest note against each answer
  always @(posedge clk) begin : mon
    logic [15:0] e;
    logic [9:0] d;
    if (rdPend) begin
      e = regQ.size() ? regQ.pop_front() : 16'hxxxx;
      check(17'(regRdData & e[15:8]), 17'(e[7:0]));
    end
    if (dbgAck) begin
      d = dbgQ.size() ? dbgQ.pop_front() : 10'hxxx;
      check({8'h0, dbgDenied, dbgRdData & {8{d[9] | d[8]}}}, {8'h0, d[8:0]});
    end
    rdPend = regRd;
  end
  // watchdog
  initial begin
    #(50 * 20000);
    nFail++;
    wrapUp();
  end
  // main sequence
  initial begin : main
    int n, ms;
    logic [7:0] cs, bs, c1;
    logic [15:0] a;
    logic pin;
    {regWr, regRd, dbgReq, dbgWrite, dbgErase, rdPend, ld} = '0;
    {regAddr, regWrData, dbgAddr, dbgWrData, ldCfg0, ldCfg1, ldCode, ldBoot, ldKey} = '0;
    dbgSpace = SP_FLASH;
    lagV = 8'h01;
    portFPin6 = 1'b1;
    sysRst = 1'b1;
    nFail = 0;
    nTests = 0;
    void'($urandom(67));
    // supply decode, start-up delay, region sizes, read-only fuse copies
    for (int c = 0; c < 8; c++) begin
      cs = 8'($urandom_range(64, 1));
      bs = (c == 0) ? 8'h00 : 8'($urandom_range(int'(cs), 1));
      c1 = {3'h0, 2'(c), 3'(c)};
      boot(8'h00, c1, cs, bs, KEY_VALID, n);
      ms = (c == 0) ? 0 : (1 << (c - 1));
      check(17'(n >= ms * 4 && n <= ms * 4 + 8), 17'h1);
      check({15'h0, supplyDual, supplySingle}, {15'h0, 2'(c) == 2'h1, 2'(c) == 2'h2});
      check(codeEndAddr, {cs, 9'h000});
      check(bootEndAddr, (bs == 8'h00) ? FLASH_BYTES : {bs, 9'h000});
      rd(OFF_CODE_REGION, 8'hff, cs);
      rd(OFF_BOOT_REGION, 8'hff, bs);
      wr(OFF_SYS_CONFIG_1, ~c1);
      rd(OFF_SYS_CONFIG_1, 8'hff, c1);
      rd(OFF_STATUS, 8'h1b, {3'h0, 2'(c) == 2'h0 || 2'(c) == 2'h3, 4'ha});
      wr(OFF_CONTROL, 8'h01);
      rd(OFF_STATUS, 8'h08, 8'h00);
    end
    // pin as general input, then as reset input
    for (int p = 0; p < 2; p++) begin
      boot({4'h0, 1'(p), 3'h0}, 8'h0b, 8'h10, 8'h04, KEY_VALID, n);
      for (int i = 0; i < 4; i++) begin
        pin = i[0] ? ~pin : 1'($urandom);
        @(posedge clk);
        portFPin6 <= pin;
        repeat (4) @(posedge clk);
        #1;
        check({15'h0, extResetReq, pinGpioIn}, {15'h0, 1'(p) & ~pin, ~1'(p) & pin});
      end
    end
    portFPin6 <= 1'b1;
    // unlocked accesses, then lock by a bad key byte
    a = 16'($urandom);
    dbg(SP_FLASH, 1'b0, a, 8'h00, {2'b10, a[7:0] ^ 8'h5a});
    dbg(SP_FUSE, 1'b0, 16'(OFF_SYS_CONFIG_1), 8'h00, {2'b10, 8'h0b});
    dbg(SP_LOCK, 1'b0, 16'h0003, 8'h00, {2'b10, KEY_VALID[31:24]});
    dbg(SP_SIGNATURE, 1'b1, a, 8'h33, 10'h100);
    dbg(SP_FUSE, 1'b1, 16'(OFF_SYS_CONFIG_1), 8'h0b, 10'h000);
    dbg(SP_LOCK, 1'b1, 16'h0000, 8'h00, 10'h000);
    repeat (4) @(posedge clk);
    rd(OFF_STATUS, 8'h01, 8'h01);
    for (int s = 0; s < 8; s++) begin
      dbg(fla_space_t'(s), 1'b0, a, 8'h00, 10'h300);
      dbg(fla_space_t'(s), 1'b1, a, 8'h5a, (s == 4) ? 10'h000 : 10'h100);
    end
    rd(OFF_SYS_CONFIG_1, 8'hff, 8'h0b);
    check({5'h0, lastWr}, {5'h0, 1'b1, SP_USER_CFG, 8'h5a});
    erase(8'd20, 1'b1);
    // keep bit set: erase leaves the eeprom alone
    boot(8'h01, 8'h0b, 8'h10, 8'h04, KEY_VALID ^ (32'h1 << $urandom_range(31, 0)), n);
    rd(OFF_STATUS, 8'h01, 8'h01);
    erase(8'd1, 1'b0);
    repeat (4) @(posedge clk);
    check(17'(dbgQ.size() + regQ.size()), 17'h0);
    wrapUp();
  end
endmodule // fla_fuse_lock_bench
`default_nettype wire
